// ==== rtl/pioc_consts.svh ====
// register offsets, reset values and timing counts of the parallel I/O pin controller
//
// Function
// R1: ownership status bit n shows whether the controller owns pin n; follows take/release.
// R2: ownership status resets to a port-dependent pattern, one for port A, one for B.
// R3: ownership bit one means controller active, zero means peripheral active.
// R4: output-enable write sets the driver enable for each pin written one.
// R5: while a peripheral owns a pin, enable changes are stored but not applied.
// R6: output-disable write clears the driver enable for each pin written one.
// R7: output status resets to zero, reads one per output line.
// R8: filter-enable write selects the glitch filter per pin, regardless of ownership.
// R9: filter-disable write deselects the glitch filter per pin, regardless of ownership.
// R10: filter status resets to zero; filter applies to peripheral and controller input.
// R11: with filter selected and clock stopped, the filtered value holds its state.
// R12: set-output write sets stored output data for each pin written one.
// R13: clear-output write clears stored output data for each pin written one.
// R14: stored data drives a pin only when controller-owned and output-enabled.
// R15: output data status resets to zero and returns the stored output data.
// R16: pin readback returns the actual pin level always, whatever ownership or direction; code returns the synchronised level, filtered where selected.
// R17: owner take gives the controller the pin, holds peripheral input at zero.
// R18: driver active only when owned and output-enabled; level equals stored data.
`ifndef PIOC_CONSTS_SVH
`define PIOC_CONSTS_SVH

// -----------------------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------------------
`define PIOC_OFS_OWNER_TAKE 6'h00
`define PIOC_OFS_OWNER_RELEASE 6'h04
`define PIOC_OFS_OWNER_STATUS 6'h08
`define PIOC_OFS_OE_SET 6'h10
`define PIOC_OFS_OE_CLEAR 6'h14
`define PIOC_OFS_OE_STATUS 6'h18
`define PIOC_OFS_GF_SET 6'h20
`define PIOC_OFS_GF_CLEAR 6'h24
`define PIOC_OFS_GF_STATUS 6'h28
`define PIOC_OFS_OUT_SET 6'h30
`define PIOC_OFS_OUT_CLEAR 6'h34
`define PIOC_OFS_OUT_STATUS 6'h38
`define PIOC_OFS_PIN_LEVEL 6'h3C

// -----------------------------------------------------------------------------
// reset values and timing
// -----------------------------------------------------------------------------
`define PIOC_OWNER_RST_A 32'h03FFFFFF
`define PIOC_OWNER_RST_B 32'h00FFFFFF
`define PIOC_ZERO_RST 32'h00000000
// glitch filter passes a level once it has stood one clock cycle more than this many
`define PIOC_FILTER_CYCLES 2

`endif

// ==== rtl/pioc_pkg.sv ====
// types shared by the parallel I/O pin controller files
package pioc_pkg;

  // axi response codes for write and read
  typedef logic [1:0] pioc_resp_t;

  // one word of pin-side signals travelling together
  typedef struct packed {
    logic [31:0] level;
    logic [31:0] enable;
  } pioc_drive_s;

  // read channel state
  typedef enum logic [0:0] {
    PIOC_RD_IDLE,
    PIOC_RD_BUSY
  } pioc_rd_e;

  // write channel state
  typedef enum logic [0:0] {
    PIOC_WR_IDLE,
    PIOC_WR_RESP
  } pioc_wr_e;

endpackage : pioc_pkg

// ==== rtl/pioc_pin_filter.sv ====
// per-pin input synchroniser and glitch filter
`timescale 1ns/1ps
`default_nettype none
`include "pioc_consts.svh"

module pioc_pin_filter #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pin side
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] filter_on,
  // filtered level
  output logic [WIDTH-1:0] level_out
);

  // elaboration-time guard: the register word has room for 32 pins at most
  if (WIDTH < 1 || WIDTH > 32)
  begin : g_width_check
    $error("pioc_pin_filter: WIDTH must be 1..32");
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_pin
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic [1:0] cnt_q;
      logic lvl_q;

      // three-stage synchroniser; only s2 and s3 are compared
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end
        else
        begin
          s1_q <= pin_in[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end

      // filter: a change must stand for a whole run; a stopped clock freezes it
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          cnt_q <= 2'h0;
          lvl_q <= 1'b0;
        end
        else if (s2_q != s3_q)
          cnt_q <= 2'h0;
        else if (s3_q == lvl_q)
          cnt_q <= 2'h0;
        else if (!filter_on[g] || cnt_q >= 2'(`PIOC_FILTER_CYCLES - 1)) // see R10 see R11
        begin
          lvl_q <= s3_q;
          cnt_q <= 2'h0;
        end
        else
          cnt_q <= cnt_q + 2'h1;
      end

      assign level_out[g] = lvl_q;
    end
  endgenerate

endmodule // pioc_pin_filter
`default_nettype wire

// ==== rtl/pioc_top.sv ====
// parallel I/O pin controller: AXI4-Lite registers, pin drive and readback
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "pioc_consts.svh"

module pioc_top
  import pioc_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter bit PORT_B = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // physical pins
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe,
  // multiplexed peripheral
  input wire logic [WIDTH-1:0] periph_out,
  input wire logic [WIDTH-1:0] periph_oe,
  output logic [WIDTH-1:0] periph_in
);

  // response codes shared by the write and read channels
  localparam pioc_resp_t RESP_OKAY = 2'h0;
  localparam pioc_resp_t RESP_SLVERR = 2'h2;

  // elaboration-time guard: the register word has room for 32 pins at most
  if (WIDTH < 1 || WIDTH > 32)
  begin : g_width_check
    $error("pioc_top: WIDTH must be 1..32");
  end

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [WIDTH-1:0] owner_q;
  logic [WIDTH-1:0] oe_q;
  logic [WIDTH-1:0] gf_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] level;
  pioc_drive_s drive;

  pioc_wr_e wr_q;
  pioc_rd_e rd_q;
  logic aw_held_q;
  logic w_held_q;
  logic [5:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] wmask;
  logic [31:0] rd_word;
  logic rd_hit;

  // ---------------------------------------------------------------------------
  // write channel: address and data taken in either order
  // ---------------------------------------------------------------------------
  // both arrive, then one cycle to apply and raise bvalid
  // limitation: one write in flight; a second waits until the response is taken
  assign wr_fire = (wr_q == PIOC_WR_IDLE) && aw_held_q && w_held_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      awaddr_q <= 6'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held_q <= 1'b0;
  end

  // readies are registers so each is taken once per transfer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready)
                       && wr_q == PIOC_WR_IDLE;
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready)
                      && wr_q == PIOC_WR_IDLE;
    end
  end

  // response: unmapped or read-only offsets answer slverr
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_q <= PIOC_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      unique case (wr_q)
        PIOC_WR_IDLE:
          if (wr_fire)
          begin
            wr_q <= PIOC_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
          end
        PIOC_WR_RESP:
          if (s_axi_bready)
          begin
            wr_q <= PIOC_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
      endcase
    end
  end

  // byte strobes gate which pins a set or clear write touches
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      wmask[i*8 +: 8] = wstrb_q[i] ? wdata_q[i*8 +: 8] : 8'h00;
  end

  // only the write-only offsets accept data; status places and holes are refused
  always_comb
  begin
    unique case (awaddr_q)
      `PIOC_OFS_OWNER_TAKE, `PIOC_OFS_OWNER_RELEASE, `PIOC_OFS_OE_SET,
      `PIOC_OFS_OE_CLEAR, `PIOC_OFS_GF_SET, `PIOC_OFS_GF_CLEAR,
      `PIOC_OFS_OUT_SET, `PIOC_OFS_OUT_CLEAR: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------------------
  // ownership; reset pattern depends on port, one means controller owns
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      owner_q <= WIDTH'(PORT_B ? `PIOC_OWNER_RST_B : `PIOC_OWNER_RST_A); // see R2
    else if (wr_fire && awaddr_q == `PIOC_OFS_OWNER_TAKE)
      owner_q <= owner_q | wmask[WIDTH-1:0]; // see R1 see R17
    else if (wr_fire && awaddr_q == `PIOC_OFS_OWNER_RELEASE)
      owner_q <= owner_q & ~wmask[WIDTH-1:0]; // see R1 see R17
  end

  // output enable is stored even for peripheral-owned pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      oe_q <= WIDTH'(`PIOC_ZERO_RST); // see R7
    else if (wr_fire && awaddr_q == `PIOC_OFS_OE_SET)
      oe_q <= oe_q | wmask[WIDTH-1:0]; // see R4 see R5
    else if (wr_fire && awaddr_q == `PIOC_OFS_OE_CLEAR)
      oe_q <= oe_q & ~wmask[WIDTH-1:0]; // see R6 see R5
  end

  // glitch filter selection ignores ownership
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      gf_q <= WIDTH'(`PIOC_ZERO_RST); // see R10
    else if (wr_fire && awaddr_q == `PIOC_OFS_GF_SET)
      gf_q <= gf_q | wmask[WIDTH-1:0]; // see R8
    else if (wr_fire && awaddr_q == `PIOC_OFS_GF_CLEAR)
      gf_q <= gf_q & ~wmask[WIDTH-1:0]; // see R9
  end

  // stored output data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      out_q <= WIDTH'(`PIOC_ZERO_RST); // see R15
    else if (wr_fire && awaddr_q == `PIOC_OFS_OUT_SET)
      out_q <= out_q | wmask[WIDTH-1:0]; // see R12
    else if (wr_fire && awaddr_q == `PIOC_OFS_OUT_CLEAR)
      out_q <= out_q & ~wmask[WIDTH-1:0]; // see R13
  end

  // ---------------------------------------------------------------------------
  // pin input path
  // ---------------------------------------------------------------------------
  pioc_pin_filter #(
    .WIDTH(WIDTH)
  ) u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(pin_i),
    .filter_on(gf_q),
    .level_out(level)
  );

  // ---------------------------------------------------------------------------
  // pin drive: owner picks controller or peripheral per pin
  // ---------------------------------------------------------------------------
  // per-pin selection between controller settings and the peripheral's own
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      if (owner_q[i]) // see R3
      begin
        drive.enable[i] = oe_q[i]; // see R14 see R18
        drive.level[i] = out_q[i]; // see R18
      end
      else
      begin
        drive.enable[i] = periph_oe[i];
        drive.level[i] = periph_out[i];
      end
    end
    for (int i = WIDTH; i < 32; i++)
    begin
      drive.enable[i] = 1'b0;
      drive.level[i] = 1'b0;
    end
  end

  // outputs registered; peripheral input held low while controller owns it
  // a cycle of pad latency is traded for outputs free of decode glitches
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_o <= '0;
      pin_oe <= '0;
      periph_in <= '0;
    end
    else
    begin
      pin_o <= drive.level[WIDTH-1:0];
      pin_oe <= drive.enable[WIDTH-1:0];
      periph_in <= level & ~owner_q; // see R17 see R10
    end
  end

  // ---------------------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------------------
  // status decode straight from the registers; write-only places and holes read zero
  always_comb
  begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `PIOC_OFS_OWNER_STATUS: rd_word[WIDTH-1:0] = owner_q; // see R1
      `PIOC_OFS_OE_STATUS: rd_word[WIDTH-1:0] = oe_q; // see R7
      `PIOC_OFS_GF_STATUS: rd_word[WIDTH-1:0] = gf_q; // see R10
      `PIOC_OFS_OUT_STATUS: rd_word[WIDTH-1:0] = out_q; // see R15
      `PIOC_OFS_PIN_LEVEL: rd_word[WIDTH-1:0] = level; // see R16
      default: rd_hit = 1'b0;
    endcase
  end

  // one read at a time; answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_q <= PIOC_RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      unique case (rd_q)
        PIOC_RD_IDLE:
          if (s_axi_arvalid && s_axi_arready)
          begin
            rd_q <= PIOC_RD_BUSY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
          end
          else
            s_axi_arready <= 1'b1;
        PIOC_RD_BUSY:
          if (s_axi_rready)
          begin
            rd_q <= PIOC_RD_IDLE;
            s_axi_rvalid <= 1'b0;
          end
      endcase
    end
  end

endmodule // pioc_top
`default_nettype wire

// ==== test/pioc_monitor.sv ====
// port-level assertion checker for the parallel I/O pin controller
`timescale 1ns/1ps
`default_nettype none
`include "pioc_consts.svh"
module pioc_monitor #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pads and peripheral
  input wire logic [WIDTH-1:0] pin_o,
  input wire logic [WIDTH-1:0] pin_oe,
  input wire logic [WIDTH-1:0] periph_out,
  input wire logic [WIDTH-1:0] periph_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // answers stand until the master takes them
  chk_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  // write: one cycle to apply, bvalid seen the edge after; read: answered next edge
  chk_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // no second request while an answer is pending
  chk_write_busy:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  chk_read_busy:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  // the oe-set write-only place reads as zero with an error
  chk_wo_read:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `PIOC_OFS_OE_SET
      |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("write-only place readable");
  // pads move only after a write or a peripheral change
  chk_pin_quiet:
    assert property ($past(aresetn) && !s_axi_bvalid && $stable(periph_oe)
      && $stable(periph_out) |=> $stable(pin_oe) && $stable(pin_o))
    else $error("pad changed without cause");
endmodule // pioc_monitor

bind pioc_top pioc_monitor #(.WIDTH(WIDTH)) u_pioc_monitor (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_o(pin_o),
  .pin_oe(pin_oe), .periph_out(periph_out), .periph_oe(periph_oe));
`default_nettype wire

// ==== test/pioc_pin_model.sv ====
// behavioural model of the pads and the outside world beyond them
`timescale 1ns/1ps
`default_nettype none
module pioc_pin_model (
  // pad side of the controller
  input wire logic [31:0] pin_o,
  input wire logic [31:0] pin_oe,
  // level the outside world holds where nobody drives
  input wire logic [31:0] ext_lvl,
  // resolved pad level
  output logic [31:0] pin_i
);
  // a driven pad shows its driver; an idle one follows the outside, never the last value
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
endmodule // pioc_pin_model
`default_nettype wire

// ==== test/pioc_top_tb_top.sv ====
// self-checking bench for the parallel I/O pin controller
`timescale 1ns/1ps
`default_nettype none
`include "pioc_consts.svh"
module pioc_top_tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [5:0] awaddr = 6'h0, araddr = 6'h0;
  logic [31:0] wdata = 32'h0, ext = 32'hA5A5C3C0;
  logic [31:0] periph_out = 32'h8, periph_oe = 32'h4;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, seen;
  logic [31:0] rdata, rdata_b, pin_i, pin_o, pin_oe, periph_in;
  int fails = 0, checked = 0;

  // 100 MHz clock
  always #5 aclk = ~aclk;

  pioc_top #(.WIDTH(32), .PORT_B(1'h0)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .periph_out(periph_out), .periph_oe(periph_oe),
    .periph_in(periph_in));
  pioc_pin_model u_pins (.pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext), .pin_i(pin_i));
  // port B variant on the same bus; only its read data is compared
  pioc_top #(.WIDTH(32), .PORT_B(1'h1)) DUT_B (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(rdata_b),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready), .pin_i(pin_i), .pin_o(),
    .pin_oe(), .periph_out(periph_out), .periph_oe(periph_oe), .periph_in());

  // --------
  // bus tasks
  // --------
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // address and data offered together, each released when taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0,
    input logic [3:0] s = 4'hF);
    logic pa, pw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    pa = 1'h1;
    pw = 1'h1;
    while (pa || pw)
    begin
      @(posedge aclk);
      pa = pa && !awready;
      pw = pw && !wready;
      awvalid <= pa;
      wvalid <= pw;
    end
    // bready waits for the answer so the slave must hold it
    while (bvalid !== 1'h1) @(posedge aclk);
    bready <= 1'h1;
    @(posedge aclk);
    bready <= 1'h0;
    check("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    @(posedge aclk);
    while (arready !== 1'h1) @(posedge aclk);
    arvalid <= 1'h0;
    while (rvalid !== 1'h1) @(posedge aclk);
    rready <= 1'h1;
    @(posedge aclk);
    rready <= 1'h0;
    check("rdata", rdata, exp);
    check("rresp", {30'h0, rresp}, {30'h0, er});
  endtask

  task conclude;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`PIOC_OFS_OWNER_STATUS, `PIOC_OWNER_RST_A);
    check("owner_b", rdata_b, `PIOC_OWNER_RST_B);
    rd(`PIOC_OFS_OE_STATUS, 32'h0);
    rd(`PIOC_OFS_GF_STATUS, 32'h0);
    rd(`PIOC_OFS_OUT_STATUS, 32'h0);
    wr(`PIOC_OFS_OWNER_RELEASE, 32'hF);
    rd(`PIOC_OFS_OWNER_STATUS, 32'h03FFFFF0);
    wr(`PIOC_OFS_OWNER_TAKE, 32'h1);
    rd(`PIOC_OFS_OWNER_STATUS, 32'h03FFFFF1);
    wr(`PIOC_OFS_OE_SET, 32'hFF);
    wr(`PIOC_OFS_OE_CLEAR, 32'hF0);
    rd(`PIOC_OFS_OE_STATUS, 32'hF);
    wr(`PIOC_OFS_OUT_SET, 32'h3);
    wr(`PIOC_OFS_OUT_CLEAR, 32'h2);
    rd(`PIOC_OFS_OUT_STATUS, 32'h1);
    check("pin_oe", pin_oe, 32'h5);
    check("pin_o", pin_o, 32'h9);
    check("periph_in", {31'h0, periph_in[0]}, 32'h0);
    // enables stored while the peripheral owned the pins now reach them
    wr(`PIOC_OFS_OWNER_TAKE, 32'hE);
    repeat (2) @(posedge aclk);
    check("pin_oe", pin_oe, 32'hF);
    check("pin_o", pin_o, 32'h1);
    rd(`PIOC_OFS_PIN_LEVEL, 32'hA5A5C3C1);
    ext <= 32'h5A5A3C30;
    repeat (6) @(posedge aclk);
    rd(`PIOC_OFS_PIN_LEVEL, 32'h5A5A3C31);
    wr(`PIOC_OFS_GF_SET, 32'h1000F000);
    rd(`PIOC_OFS_GF_STATUS, 32'h1000F000);
    wr(`PIOC_OFS_GF_CLEAR, 32'hF000);
    rd(`PIOC_OFS_GF_STATUS, 32'h10000000);
    // two-cycle glitch: long enough for the synchroniser, too short for the filter
    ext <= ext ^ 32'h30000000;
    repeat (2) @(posedge aclk);
    ext <= ext ^ 32'h30000000;
    seen = 2'h0;
    repeat (12)
    begin
      @(posedge aclk);
      seen = seen | (periph_in[29:28] ^ 2'h1);
    end
    check("glitch", {30'h0, seen}, 32'h2);
    wr(6'h0C, 32'hFFFFFFFF, 2'h2);
    wr(`PIOC_OFS_OWNER_STATUS, 32'h0, 2'h2);
    rd(`PIOC_OFS_OWNER_STATUS, 32'h03FFFFFF);
    rd(`PIOC_OFS_OE_SET, 32'h0, 2'h2);
    rd(6'h0C, 32'h0, 2'h2);
    wr(`PIOC_OFS_OUT_SET, 32'hFFFFFFFF, 2'h0, 4'h2);
    rd(`PIOC_OFS_OUT_STATUS, 32'hFF01);
    conclude();
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    conclude();
  end
endmodule // pioc_top_tb_top
`default_nettype wire
